// ---- include/ulbc_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Shared bus between device and link
// ----------------------------------------
interface ulbc_if;
  // Clock pins and mode strap
  logic phy_clk;
  logic phy_clk_oe;
  logic link_clk;
  logic link_clk_oe;
  logic clk_in_mode;
  logic bus_clk;
  // Control pins
  logic chip_reset_low;
  logic stp;
  logic dir;
  logic dir_oe;
  logic nxt;
  logic nxt_oe;
  logic dir_seen;
  logic nxt_seen;
  // Shared data pins
  logic [ulbc_pkg::DATA_W-1:0] phy_data;
  logic phy_data_oe;
  logic [ulbc_pkg::DATA_W-1:0] link_data;
  logic link_data_oe;
  logic [ulbc_pkg::DATA_W-1:0] data;

  // Wire resolution; an undriven pin reads low
  assign bus_clk = (phy_clk_oe & phy_clk) | (link_clk_oe & link_clk);
  assign dir_seen = dir_oe & dir;
  assign nxt_seen = nxt_oe & nxt;
  assign data = phy_data_oe ? phy_data : (link_data_oe ? link_data : ulbc_pkg::IDLE_BYTE);

  modport phy (
    input bus_clk, data, stp, chip_reset_low, clk_in_mode,
    output phy_clk, phy_clk_oe, dir, dir_oe, nxt, nxt_oe, phy_data, phy_data_oe
  );
  modport link (
    input bus_clk, data, dir_seen, nxt_seen,
    output link_clk, link_clk_oe, clk_in_mode, chip_reset_low, stp, link_data, link_data_oe
  );
endinterface
`default_nettype wire

// ---- include/ulbc_pkg.sv ----
`default_nettype none
// ----------------------------------------
// Shared constants for both bus ends
// ----------------------------------------
package ulbc_pkg;
  // Bus data width, bit 0 least significant
  localparam int DATA_W = 8;
  // Core clock period
  localparam int CLK_PERIOD_NS = 20;
  // Least chip reset low time
  localparam int RST_MIN_NS = 1000;
  // Least time rounds up to whole cycles
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 6;
  localparam logic [RST_CNT_W-1:0] RST_MIN_CNT = RST_CNT_W'(RST_MIN_CYC);
  // Bus clock divider: half period in core cycles, minus one
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] BUS_HALF_CNT = 3'h3;
  // Value seen on the data bus when nobody has anything to say
  localparam logic [7:0] IDLE_BYTE = 8'h00;

  // Device end states
  typedef enum logic [4:0] {
    PS_IDLE = 5'h01,
    PS_TURN_OUT = 5'h02,
    PS_SEND = 5'h04,
    PS_TURN_IN = 5'h08,
    PS_RECV = 5'h10
  } ulbc_phy_state_type;

  // Link end states
  typedef enum logic [4:0] {
    LS_IDLE = 5'h01,
    LS_SEND = 5'h02,
    LS_STOP = 5'h04,
    LS_TURN = 5'h08,
    LS_RECV = 5'h10
  } ulbc_link_state_type;
endpackage
`default_nettype wire

// ---- src/ulbc_link_end.sv ----
`timescale 1ns/1ns
`default_nettype none
module ulbc_link_end (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bus pins
  ulbc_if.link bus,
  // Configuration and chip reset control
  input wire logic clk_in_mode_i,
  input wire logic reset_req_i,
  output logic reset_busy_o,
  // Stream toward the device
  input wire logic tx_valid_i,
  input wire logic [ulbc_pkg::DATA_W-1:0] tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  // Stream from the device
  output logic rx_valid_o,
  output logic [ulbc_pkg::DATA_W-1:0] rx_data_o,
  output logic rx_end_o
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int SW = ulbc_pkg::DATA_W + 3;

  logic [SW-1:0] meta;
  logic [SW-1:0] samp;
  logic clk_prev;

  // Pins pass two flops together
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      samp <= '0;
      clk_prev <= 1'b0;
    end else begin
      meta <= {bus.bus_clk, bus.dir_seen, bus.nxt_seen, bus.data};
      samp <= meta;
      clk_prev <= samp[SW-1];
    end
  end

  wire dir_s = samp[SW-2];
  wire nxt_s = samp[SW-3];
  wire [ulbc_pkg::DATA_W-1:0] data_s = samp[ulbc_pkg::DATA_W-1:0];
  wire bus_edge = samp[SW-1] & ~clk_prev;

  // ----------------------------------------
  // Chip reset pulse and clock source
  // ----------------------------------------
  logic [ulbc_pkg::RST_CNT_W-1:0] rst_cnt;
  logic [ulbc_pkg::DIV_W-1:0] div_cnt;
  logic link_clk;

  // Pulse is held the full least time, also once after power-up
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rst_cnt <= ulbc_pkg::RST_MIN_CNT;
    end else if (reset_req_i && rst_cnt == '0) begin
      rst_cnt <= ulbc_pkg::RST_MIN_CNT;
    end else if (rst_cnt != '0) begin
      rst_cnt <= rst_cnt - 1'b1;
    end
  end

  // Divider makes the bus clock in clock-in mode
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !clk_in_mode_i) begin
      div_cnt <= '0;
      link_clk <= 1'b0;
    end else if (div_cnt == ulbc_pkg::BUS_HALF_CNT) begin
      div_cnt <= '0;
      link_clk <= ~link_clk;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  wire chip_held = (rst_cnt != '0);
  wire sreset = ~rst_n_i | chip_held;

  // ----------------------------------------
  // Link state machine
  // ----------------------------------------
  ulbc_pkg::ulbc_link_state_type state;
  ulbc_pkg::ulbc_link_state_type next_state;
  logic [ulbc_pkg::DATA_W-1:0] tx_byte;
  logic tx_last_q;

  wire in_idle = (state == ulbc_pkg::LS_IDLE);
  wire in_send = (state == ulbc_pkg::LS_SEND);
  wire in_turn = (state == ulbc_pkg::LS_TURN);
  wire in_recv = (state == ulbc_pkg::LS_RECV);
  // First byte in idle, next one each time the device accepts
  wire load_slot = bus_edge & ~dir_s & tx_valid_i & (in_idle | (in_send & nxt_s & ~tx_last_q));
  wire rx_take = bus_edge & dir_s & (in_turn | in_recv);

  // Next state; the device taking the bus aborts a send
  always_comb begin
    next_state = state;
    case (state)
      ulbc_pkg::LS_IDLE: begin
        if (dir_s) begin
          next_state = ulbc_pkg::LS_TURN;
        end else if (tx_valid_i) begin
          next_state = ulbc_pkg::LS_SEND;
        end
      end
      ulbc_pkg::LS_SEND: begin
        if (dir_s) begin
          next_state = ulbc_pkg::LS_TURN;
        end else if (nxt_s && (tx_last_q || !tx_valid_i)) begin
          next_state = ulbc_pkg::LS_STOP;
        end
      end
      ulbc_pkg::LS_STOP: begin
        next_state = dir_s ? ulbc_pkg::LS_TURN : ulbc_pkg::LS_IDLE;
      end
      ulbc_pkg::LS_TURN: begin
        next_state = dir_s ? ulbc_pkg::LS_RECV : ulbc_pkg::LS_IDLE;
      end
      ulbc_pkg::LS_RECV: begin
        if (!dir_s) begin
          next_state = ulbc_pkg::LS_TURN;
        end
      end
      default: begin
        next_state = ulbc_pkg::LS_IDLE;
      end
    endcase
  end

  // State, transmit byte and receive outputs
  always_ff @(posedge clk_i) begin
    if (sreset) begin
      state <= ulbc_pkg::LS_IDLE;
      tx_byte <= ulbc_pkg::IDLE_BYTE;
      tx_last_q <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o <= ulbc_pkg::IDLE_BYTE;
      rx_end_o <= 1'b0;
    end else begin
      rx_valid_o <= rx_take;
      rx_end_o <= bus_edge & in_recv & ~dir_s;
      if (rx_take) begin
        rx_data_o <= data_s;
      end
      if (bus_edge) begin
        state <= next_state;
      end
      if (load_slot) begin
        tx_byte <= tx_data_i;
        tx_last_q <= tx_last_i;
      end
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  assign tx_ready_o = load_slot;
  assign reset_busy_o = chip_held;
  assign bus.chip_reset_low = ~chip_held;
  assign bus.clk_in_mode = clk_in_mode_i;
  assign bus.link_clk = link_clk;
  assign bus.link_clk_oe = clk_in_mode_i;
  assign bus.stp = (state == ulbc_pkg::LS_STOP);
  // Idle byte during stop; nothing once the device owns the bus
  assign bus.link_data = in_send ? tx_byte : ulbc_pkg::IDLE_BYTE;
  assign bus.link_data_oe = (in_send | (state == ulbc_pkg::LS_STOP)) & ~dir_s;

endmodule
`default_nettype wire

// ---- src/ulbc_phy_end.sv ----
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Device with data drives direction high
// - Idle device holds direction low, listens
// - Link raises stop for one cycle
// - Byte before stop is the last
// - Reset low suspends, regulators off
// - Chip reset synchronised, accepted anytime
// - One microsecond low resets everything
// - Reset low tri-states all bus outputs
// - Clock-in mode uses link's clock
// - Next high accepts link's current byte
// - Clock-out mode device makes bus clock
// - Data bus eight bits, bit0 LSB
module ulbc_phy_end (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bus pins
  ulbc_if.phy bus,
  // Stream toward the link
  input wire logic tx_valid_i,
  input wire logic [ulbc_pkg::DATA_W-1:0] tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  // Stream from the link
  output logic rx_valid_o,
  output logic [ulbc_pkg::DATA_W-1:0] rx_data_o,
  output logic rx_end_o,
  // Power and reset status
  output logic regulators_en_o,
  output logic reset_done_o
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int SW = ulbc_pkg::DATA_W + 4;

  logic [SW-1:0] meta;
  logic [SW-1:0] samp;
  logic clk_prev;

  // All pins pass two flops together so they stay aligned to the clock sample
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      samp <= '0;
      clk_prev <= 1'b0;
    end else begin
      meta <= {bus.bus_clk, bus.stp, bus.chip_reset_low, bus.clk_in_mode, bus.data};
      samp <= meta;
      clk_prev <= samp[SW-1];
    end
  end

  // Named views of the second stage
  wire bus_clk_s = samp[SW-1];
  wire stp_s = samp[SW-2];
  wire chip_run_s = samp[SW-3];
  wire clk_in_mode_s = samp[SW-4];
  wire [ulbc_pkg::DATA_W-1:0] data_s = samp[ulbc_pkg::DATA_W-1:0];
  wire bus_edge = bus_clk_s & ~clk_prev;
  // Suspension is a plain level; the low chip reset reads as zero at power-up
  wire suspended = ~chip_run_s;
  wire sreset = ~rst_n_i | suspended;

  // ----------------------------------------
  // Bus clock generation
  // ----------------------------------------
  logic [ulbc_pkg::DIV_W-1:0] div_cnt;
  logic phy_clk;

  // Divider runs only when this end owns the clock
  always_ff @(posedge clk_i) begin
    if (sreset || clk_in_mode_s) begin
      div_cnt <= '0;
      phy_clk <= 1'b0;
    end else if (div_cnt == ulbc_pkg::BUS_HALF_CNT) begin
      div_cnt <= '0;
      phy_clk <= ~phy_clk;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // ----------------------------------------
  // Chip reset length tracking
  // ----------------------------------------
  logic [ulbc_pkg::RST_CNT_W-1:0] low_cnt;
  wire low_long = (low_cnt == ulbc_pkg::RST_MIN_CNT);

  // Saturating count of low time; a short glitch resets the same state but gives no reset done pulse
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      low_cnt <= '0;
      reset_done_o <= 1'b0;
    end else begin
      reset_done_o <= chip_run_s & low_long;
      if (chip_run_s) begin
        low_cnt <= '0;
      end else if (!low_long) begin
        low_cnt <= low_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Bus ownership state machine
  // ----------------------------------------
  ulbc_pkg::ulbc_phy_state_type state;
  ulbc_pkg::ulbc_phy_state_type next_state;
  logic [ulbc_pkg::DATA_W-1:0] tx_byte;
  logic tx_last_q;

  // Decodes of the current state
  wire in_send = (state == ulbc_pkg::PS_SEND);
  wire in_recv = (state == ulbc_pkg::PS_RECV);
  wire in_turn_out = (state == ulbc_pkg::PS_TURN_OUT);
  wire link_cmd = (data_s != ulbc_pkg::IDLE_BYTE);
  // A byte slot opens in the turnaround and after each non-final byte
  wire load_slot = bus_edge & (in_turn_out | (in_send & ~tx_last_q));
  wire rx_take = bus_edge & in_recv & ~stp_s;
  wire rx_stop = bus_edge & in_recv & stp_s;

  // Next state; a listening link command wins over a local send request
  always_comb begin
    next_state = state;
    case (state)
      ulbc_pkg::PS_IDLE: begin
        if (link_cmd) begin
          next_state = ulbc_pkg::PS_RECV;
        end else if (tx_valid_i) begin
          next_state = ulbc_pkg::PS_TURN_OUT;
        end
      end
      ulbc_pkg::PS_TURN_OUT: begin
        next_state = ulbc_pkg::PS_SEND;
      end
      ulbc_pkg::PS_SEND: begin
        if (tx_last_q) begin
          next_state = ulbc_pkg::PS_TURN_IN;
        end
      end
      ulbc_pkg::PS_TURN_IN: begin
        next_state = ulbc_pkg::PS_IDLE;
      end
      ulbc_pkg::PS_RECV: begin
        if (stp_s) begin
          next_state = ulbc_pkg::PS_IDLE;
        end
      end
      default: begin
        next_state = ulbc_pkg::PS_IDLE;
      end
    endcase
  end

  // State advances only on bus clock edges
  always_ff @(posedge clk_i) begin
    if (sreset) begin
      state <= ulbc_pkg::PS_IDLE;
    end else if (bus_edge) begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Transmit byte register
  // ----------------------------------------
  // An empty source ends the packet rather than stalling the bus
  always_ff @(posedge clk_i) begin
    if (sreset) begin
      tx_byte <= ulbc_pkg::IDLE_BYTE;
      tx_last_q <= 1'b0;
    end else if (load_slot) begin
      tx_byte <= tx_valid_i ? tx_data_i : ulbc_pkg::IDLE_BYTE;
      tx_last_q <= tx_valid_i ? tx_last_i : 1'b1;
    end
  end

  assign tx_ready_o = load_slot;

  // ----------------------------------------
  // Receive byte register
  // ----------------------------------------
  // Each byte seen while next is high is taken; stop marks the end
  always_ff @(posedge clk_i) begin
    if (sreset) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= ulbc_pkg::IDLE_BYTE;
      rx_end_o <= 1'b0;
    end else begin
      rx_valid_o <= rx_take;
      rx_end_o <= rx_stop;
      if (rx_take) begin
        rx_data_o <= data_s;
      end
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Every output enable drops while the chip reset is low
  assign bus.phy_clk = phy_clk;
  assign bus.phy_clk_oe = chip_run_s & ~clk_in_mode_s;
  assign bus.dir = in_turn_out | in_send;
  assign bus.dir_oe = chip_run_s;
  assign bus.nxt = in_recv;
  assign bus.nxt_oe = chip_run_s;
  assign bus.phy_data = tx_byte;
  // Data only after the turnaround cycle, never with direction low
  assign bus.phy_data_oe = chip_run_s & in_send;
  assign regulators_en_o = chip_run_s;

endmodule
`default_nettype wire

// ---- verification/tb_ulpi_phy_bus_control.sv ----
`timescale 1ns/1ns
`default_nettype none
// --------
// Both ends joined, driven from user sides
// --------
module tb_ulpi_phy_bus_control;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mode = 1'b0;
  logic req = 1'b0;
  logic p_valid = 1'b0;
  logic p_last = 1'b0;
  logic l_valid = 1'b0;
  logic l_last = 1'b0;
  logic [7:0] p_data = 8'h00;
  logic [7:0] l_data = 8'h00;
  wire p_ready, p_rx_valid, p_rx_end, regs_en, rst_done;
  wire l_ready, l_rx_valid, l_rx_end, busy;
  wire [7:0] p_rx_data, l_rx_data;
  logic [7:0] p_got[$], l_got[$], wire_got[$];
  logic oe_q = 1'b0;
  int p_ends = 0, l_ends = 0, stp_len = 0, stp_run = 0, done_seen = 0;
  int errors = 0;
  int checked = 0;

  // Core clock, 20 ns
  always #10 clk_i = ~clk_i;

  ulbc_if bus_if ();
  ulbc_phy_end ulbc_phy_end_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if),
    .tx_valid_i(p_valid), .tx_data_i(p_data), .tx_last_i(p_last), .tx_ready_o(p_ready),
    .rx_valid_o(p_rx_valid), .rx_data_o(p_rx_data), .rx_end_o(p_rx_end),
    .regulators_en_o(regs_en), .reset_done_o(rst_done));
  ulbc_link_end ulbc_link_end_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if),
    .clk_in_mode_i(mode), .reset_req_i(req), .reset_busy_o(busy),
    .tx_valid_i(l_valid), .tx_data_i(l_data), .tx_last_i(l_last), .tx_ready_o(l_ready),
    .rx_valid_o(l_rx_valid), .rx_data_o(l_rx_data), .rx_end_o(l_rx_end));
  ulbc_chk ulbc_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_clk(bus_if.bus_clk),
    .clk_in_mode(bus_if.clk_in_mode), .phy_clk_oe(bus_if.phy_clk_oe),
    .chip_reset_low(bus_if.chip_reset_low), .stp(bus_if.stp), .dir(bus_if.dir),
    .dir_oe(bus_if.dir_oe), .nxt_oe(bus_if.nxt_oe), .phy_data_oe(bus_if.phy_data_oe),
    .link_data_oe(bus_if.link_data_oe));

  // Traffic monitor, mid-cycle so every edge has settled
  always @(negedge clk_i) begin
    if (p_rx_valid) p_got.push_back(p_rx_data);
    if (l_rx_valid) l_got.push_back(l_rx_data);
    if (bus_if.phy_data_oe && (!oe_q || bus_if.data !== wire_got[$])) wire_got.push_back(bus_if.data);
    oe_q <= bus_if.phy_data_oe;
    p_ends += p_rx_end;
    l_ends += l_rx_end;
    done_seen += rst_done;
    if (bus_if.stp) stp_run++;
    else if (stp_run > 0) stp_len = stp_run;
    if (!bus_if.stp) stp_run = 0;
  end

  // --------
  // Compare and closing
  // --------
  task automatic chk_val(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_count(string what, int exp, int got);
    checked++;
    if (got != exp) begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Offer three bytes from one end, or from both at once; hold each until the ready pulse of the end named by from_phy
  task automatic send(input bit from_phy, input logic [7:0] b[3], input bit both = 1'b0);
    int n;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      p_valid <= from_phy || both;
      l_valid <= !from_phy || both;
      p_data <= b[i];
      l_data <= b[i];
      p_last <= i == 2;
      l_last <= i == 2;
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (((from_phy ? p_ready : l_ready) !== 1'b1) && n < 200);
      chk_count("handshake", 1, int'(n < 200));
    end
    @(posedge clk_i);
    p_valid <= 1'b0;
    l_valid <= 1'b0;
  endtask

  // Bounded wait for an end marker, then a few bus periods of idle
  task automatic wait_end(input bit on_phy, input int was);
    for (int t = 0; t < 400 && (on_phy ? p_ends : l_ends) == was; t++) @(negedge clk_i);
    repeat (40) @(negedge clk_i);
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_power_up();
    int was = done_seen;
    int n = 0;
    while ((busy !== 1'b0 || n < 5) && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    repeat (40) @(negedge clk_i);
    chk_count("reset done pulses", was + 1, done_seen);
    chk_val("regulators", 8'h01, {7'h00, regs_en});
    chk_val("idle direction", 8'h00, {7'h00, bus_if.dir_seen});
    $display("test power_up done");
  endtask

  task automatic t_link_to_phy();
    logic [7:0] b[3] = '{8'h81, 8'h3C, 8'h01};
    int was = p_ends;
    p_got.delete();
    stp_len = 0;
    send(1'b0, b);
    wait_end(1'b1, was);
    chk_count("device end marks", was + 1, p_ends);
    chk_count("device bytes", 3, p_got.size());
    for (int i = 0; i < 3; i++) chk_val("device byte", b[i], p_got[i]);
    chk_count("stop cycles", 2 * (ulbc_pkg::BUS_HALF_CNT + 1), stp_len);
    $display("test link_to_phy done");
  endtask

  task automatic t_phy_to_link();
    logic [7:0] b[3] = '{8'h7E, 8'hC3, 8'h80};
    int was = l_ends;
    l_got.delete();
    wire_got.delete();
    send(1'b1, b);
    wait_end(1'b0, was);
    chk_count("link end marks", was + 1, l_ends);
    for (int i = 0; i < 3; i++) chk_val("link byte", b[i], l_got[i]);
    for (int i = 0; i < 3; i++) chk_val("wire byte", b[i], wire_got[i]);
    chk_val("direction released", 8'h00, {7'h00, bus_if.dir_seen});
    $display("test phy_to_link done");
  endtask

  // Both ends start on one bus edge; the link must yield and the device keeps the bus
  task automatic t_collide();
    logic [7:0] b[3] = '{8'h5A, 8'hA5, 8'h0F};
    int was = l_ends;
    int was_p = p_ends;
    l_got.delete();
    send(1'b1, b, 1'b1);
    wait_end(1'b0, was);
    chk_count("collide link end marks", was + 1, l_ends);
    chk_count("collide device end marks", was_p, p_ends);
    for (int i = 0; i < 3; i++) chk_val("collide link byte", b[i], l_got[i]);
    chk_val("collide direction released", 8'h00, {7'h00, bus_if.dir_seen});
    $display("test collide done");
  endtask

  task automatic t_chip_reset();
    int low = 0;
    int was = done_seen;
    @(posedge clk_i);
    req <= 1'b1;
    @(posedge clk_i);
    req <= 1'b0;
    for (int t = 0; t < 120; t++) begin
      @(negedge clk_i);
      low += !bus_if.chip_reset_low;
      if (t == 10) begin
        chk_val("busy", 8'h01, {7'h00, busy});
        chk_val("suspended", 8'h00, {7'h00, regs_en});
        chk_val("pins", 8'h00, {4'h0, bus_if.dir_oe, bus_if.nxt_oe, bus_if.phy_data_oe, bus_if.phy_clk_oe});
      end
    end
    repeat (40) @(negedge clk_i);
    chk_count("reset low cycles", ulbc_pkg::RST_MIN_CYC, low);
    chk_count("reset done pulses", was + 1, done_seen);
    chk_val("resumed", 8'h01, {7'h00, regs_en});
    $display("test chip_reset done");
  endtask

  // Main sequence, once per clock mode, with a watchdog beside it
  initial begin
    fork
      begin
        #400000;
        errors++;
        tally_and_finish();
      end
    join_none
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_i);
      mode <= m[0];
      rst_n_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_power_up();
      t_link_to_phy();
      t_phy_to_link();
      t_collide();
      t_chip_reset();
      t_link_to_phy();
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- verification/ulbc_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
// --------
// Bus protocol checker
// --------
module ulbc_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Watched bus signals
  input wire logic bus_clk,
  input wire logic clk_in_mode,
  input wire logic phy_clk_oe,
  input wire logic chip_reset_low,
  input wire logic stp,
  input wire logic dir,
  input wire logic dir_oe,
  input wire logic nxt_oe,
  input wire logic phy_data_oe,
  input wire logic link_data_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Bus clock period in core cycles; trusted only after three clean rises
  logic clk_q;
  logic [3:0] gap;
  logic [1:0] rises;
  wire bus_rise = bus_clk & ~clk_q;
  always_ff @(posedge clk_i) begin
    clk_q <= bus_clk;
    gap <= bus_rise ? 4'h0 : gap + 4'h1;
    rises <= (!rst_n_i || !chip_reset_low) ? 2'h0 : rises + {1'b0, bus_rise && rises != 2'h3};
  end

  // Steps of ownership and suspension
  sequence s_dir_up;
    $rose(dir) && dir_oe;
  endsequence
  sequence s_suspended;
    !chip_reset_low [*4];
  endsequence

  property p_no_clash; !(phy_data_oe && link_data_oe); endproperty
  property p_turnaround; s_dir_up |-> !phy_data_oe [*8]; endproperty
  property p_link_yields; s_dir_up |-> ##[0:12] !link_data_oe; endproperty
  property p_send_owns; phy_data_oe |-> dir && dir_oe; endproperty
  property p_idle_release; $fell(dir) |-> !phy_data_oe; endproperty
  property p_tristate; s_suspended |-> !(dir_oe || nxt_oe || phy_data_oe || phy_clk_oe); endproperty
  property p_stop_len; $rose(stp) |-> stp [*8] ##1 !stp; endproperty
  property p_clk_in; clk_in_mode [*4] |-> !phy_clk_oe; endproperty
  property p_clk_out; (!clk_in_mode && chip_reset_low) [*8] |-> phy_clk_oe; endproperty
  property p_period; bus_rise && rises == 2'h3 |-> gap == 4'h7; endproperty

  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive data");
  a_turnaround: assert property (p_turnaround)
    else $error("data driven without turnaround");
  a_link_yields: assert property (p_link_yields)
    else $error("link kept data after direction rose");
  a_send_owns: assert property (p_send_owns)
    else $error("device drives data without direction");
  a_idle_release: assert property (p_idle_release)
    else $error("data still driven with direction low");
  a_tristate: assert property (p_tristate)
    else $error("pins driven during chip reset");
  a_stop_len: assert property (p_stop_len)
    else $error("stop not one bus period");
  a_clk_in: assert property (p_clk_in)
    else $error("device drives clock in clock-in mode");
  a_clk_out: assert property (p_clk_out)
    else $error("device clock missing in clock-out mode");
  a_period: assert property (p_period)
    else $error("bus clock period wrong");
endmodule
`default_nettype wire
